// File: hw/dbad_top.sv
`timescale 1ns/1ps
// Functional notes
// R1 - invert address bit 0, pass it with byte-high enable to data control
// R2 - invert address bits 1..16, multiplex them onto eight memory address outputs
// R3 - row group bits 1-7,15; column group bits 9-14,8,16
// R4 - row/column control picks which group drives the memory address
// R5 - port select: bits 0..3 low if jumper fitted, high if not
// R6 - port select needs address bits 4, 5 and 7 low
// R7 - port select: bit 6 high with first jumper, low with second
// R8 - port select: bits 8..15 low if jumper fitted, else ignored
// R9 - board select needs bits 14..21 between lower and upper bounds
// R10 - board select needs bits 22, 23 matching segment settings
// R11 - bounds count 16K units up to 4M; top bits pick segment
// R12 - chip row from bit 17 and half/full setting, forwarded for readback
// R13 - during refresh drive inverted refresh count as row address
// R14 - refresh counter advances once per count pulse
// R15 - refresh counter is two cascaded four-bit stages
// R16 - about 20 ns after refresh pulse swap the address enables
// R17 - protection inhibits read and write but keeps refresh running
// R18 - array is four rows of 64K chips, 512K bytes
// R19 - byte or word transfers chosen by byte-high enable and bit 0
// R20 - master supplies at least nineteen and up to 24 address lines
// R21 - names ending in slash are active low
// R22 - board select needs window and segment match, gated by protection
module dbad_top #(
   parameter int ADDR_W = 12,
   parameter int BUS_AW = 24
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [BUS_AW-1:0] busAddrN,
   input wire logic byteHighEnableN,
   input wire logic protectRequestN,
   input wire logic rowColSel,
   input wire logic refreshPulse,
   input wire logic refreshEnd,
   output logic [7:0] memoryAddressOut,
   output logic addressBit0True,
   output logic byteHighEnableOutN,
   output logic boardSelectN,
   output logic parityPortSelect,
   output logic [3:0] chipRowSelect,
   output logic rowAddrBit17,
   output logic halfFullOut,
   output logic refreshAddressEnableN,
   output logic normalAddressEnableN,
   output logic protectActive
);
   typedef struct packed {
      logic [BUS_AW-1:0] addrS1;
      logic [BUS_AW-1:0] addrS2;
      logic byteHiS1;
      logic byteHiS2;
      logic protS1;
      logic protS2;
      dbad_pkg::dbad_ref_st_t refSt;
      logic [3:0] dlyCnt;
      logic [7:0] memAddr;
      logic adr0;
      logic byteHiOutN;
      logic bselN;
      logic portSel;
      logic [3:0] rowSel;
      logic rowBit17;
      logic halfOut;
      logic refEnN;
      logic normEnN;
      logic protect;
      logic [7:0] lower;
      logic [7:0] upper;
      logic [1:0] seg;
      logic half;
      logic [3:0] portLow;
      logic port6Hi;
      logic port6Lo;
      logic [7:0] portHigh;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } dbad_state_t;

   dbad_state_t st_r;
   dbad_state_t st_nxt;
   dbad_ref_if rc ();
   logic [BUS_AW-1:0] addrTrue;
   logic [7:0] rowGrp;
   logic [7:0] colGrp;
   logic [7:0] winVal;
   logic winHit;
   logic portHit;
   logic refOn;

   ////////////////////////////////////////////////////////////////
   // window test: 16K-unit bounds inside one 4M segment
   function automatic logic inWindow(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi,
                                     input logic [1:0] top, input logic [1:0] seg);
      inWindow = (v >= lo) && (v <= hi) && (top == seg); // R9 R10 R11
   endfunction : inWindow

   // parity port address match against the jumper settings
   function automatic logic portMatch(input logic [15:0] a, input logic [3:0] lowJ, input logic b6Hi,
                                      input logic b6Lo, input logic [7:0] highJ);
      logic ok;
      ok = ((a[3:0] ^ lowJ) == 4'hF); // R5
      ok = ok && !a[4] && !a[5] && !a[7]; // R6
      ok = ok && !(b6Hi && !a[6]) && !(b6Lo && a[6]); // R7
      ok = ok && ((a[15:8] & highJ) == 8'h00); // R8
      portMatch = ok;
   endfunction : portMatch

   ////////////////////////////////////////////////////////////////
   // address groups, taken from the synchronised true-polarity address
   assign addrTrue = st_r.addrS2;
   assign rowGrp = {addrTrue[15], addrTrue[7:1]}; // R3
   assign colGrp = {addrTrue[16], addrTrue[8], addrTrue[14:9]}; // R3
   assign winVal = addrTrue[21:14];
   assign winHit = inWindow(winVal, st_r.lower, st_r.upper, addrTrue[23:22], st_r.seg);
   assign portHit = portMatch(addrTrue[15:0], st_r.portLow, st_r.port6Hi, st_r.port6Lo, st_r.portHigh);
   assign rc.countPulse = refreshPulse; // R14

   dbad_refresh_counter #(
      .STAGES(dbad_pkg::REF_STAGES),
      .STAGE_W(dbad_pkg::REF_STAGE_W)
   ) uCounter (
      .clk(clk),
      .rst_n(rst_n),
      .rc(rc)
   );

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      refOn = 1'b0;
      // address, byte-high and protect pins cross in through two flops; bus lines inverted on entry
      st_nxt.addrS1 = ~busAddrN; // R2 R21
      st_nxt.addrS2 = st_r.addrS1;
      st_nxt.byteHiS1 = byteHighEnableN;
      st_nxt.byteHiS2 = st_r.byteHiS1;
      st_nxt.protS1 = protectRequestN;
      st_nxt.protS2 = st_r.protS1;

      // refresh sequencer: delay after the pulse, then hold until end
      case (st_r.refSt)
         dbad_pkg::REF_IDLE: begin
            if (refreshPulse) begin
               st_nxt.dlyCnt = 4'(dbad_pkg::REF_DELAY_CYC - 4'h1);
               st_nxt.refSt = (dbad_pkg::REF_DELAY_CYC == 4'h1) ? dbad_pkg::REF_RUN : dbad_pkg::REF_WAIT; // R16
            end
         end
         dbad_pkg::REF_WAIT: begin
            if (st_r.dlyCnt <= 4'h1) begin
               st_nxt.refSt = dbad_pkg::REF_RUN; // R16
            end else begin
               st_nxt.dlyCnt = 4'(st_r.dlyCnt - 4'h1);
            end
         end
         dbad_pkg::REF_RUN: begin
            if (refreshEnd) begin
               st_nxt.refSt = dbad_pkg::REF_IDLE;
            end
         end
         default: begin
            st_nxt.refSt = dbad_pkg::REF_IDLE;
         end
      endcase
      refOn = (st_nxt.refSt == dbad_pkg::REF_RUN);
      st_nxt.refEnN = !refOn; // R13 R16
      st_nxt.normEnN = refOn; // R13 R16

      // memory address mux; refresh row address goes out inverted
      if (refOn) begin
         st_nxt.memAddr = ~rc.rowCount; // R13
      end else if (rowColSel) begin
         st_nxt.memAddr = rowGrp; // R4
      end else begin
         st_nxt.memAddr = colGrp; // R4
      end

      // protection latches at the end of a refresh, so refresh keeps going
      if (refreshEnd) begin
         st_nxt.protect = !st_r.protS2; // R17
      end

      // selects and data-control pass-through
      st_nxt.adr0 = addrTrue[0]; // R1 R19
      st_nxt.byteHiOutN = st_r.byteHiS2; // R1 R19
      st_nxt.bselN = !(winHit && !st_r.protect); // R22 R17
      st_nxt.portSel = portHit;
      st_nxt.rowSel = 4'h1 << {st_r.half, addrTrue[17]}; // R12 R18
      st_nxt.rowBit17 = addrTrue[17]; // R12
      st_nxt.halfOut = st_r.half; // R12

      // apb: ready comes one cycle after setup, so every access has one wait-free access phase
      st_nxt.ready = psel && !penable && !st_r.ready;
      if (psel && !penable) begin
         st_nxt.slverr = 1'b0;
         st_nxt.rdata = 32'h0000_0000;
         if (paddr == ADDR_W'(dbad_pkg::WIN_CFG_ADDR)) begin
            st_nxt.rdata[dbad_pkg::WIN_LOWER_POS +: 8] = st_r.lower;
            st_nxt.rdata[dbad_pkg::WIN_UPPER_POS +: 8] = st_r.upper;
            st_nxt.rdata[dbad_pkg::WIN_SEG_POS +: 2] = st_r.seg;
            st_nxt.rdata[dbad_pkg::WIN_HALF_POS] = st_r.half;
         end else if (paddr == ADDR_W'(dbad_pkg::PORT_CFG_ADDR)) begin
            st_nxt.rdata[dbad_pkg::PORT_LOW_POS +: 4] = st_r.portLow;
            st_nxt.rdata[dbad_pkg::PORT_B6HI_POS] = st_r.port6Hi;
            st_nxt.rdata[dbad_pkg::PORT_B6LO_POS] = st_r.port6Lo;
            st_nxt.rdata[dbad_pkg::PORT_HIGH_POS +: 8] = st_r.portHigh;
         end else if (paddr == ADDR_W'(dbad_pkg::STATUS_ADDR)) begin
            st_nxt.rdata[dbad_pkg::STAT_ROW_POS +: 8] = rc.rowCount;
            st_nxt.rdata[dbad_pkg::STAT_BSEL_POS] = !st_r.bselN;
            st_nxt.rdata[dbad_pkg::STAT_PSEL_POS] = st_r.portSel;
            st_nxt.rdata[dbad_pkg::STAT_PROT_POS] = st_r.protect;
            st_nxt.rdata[dbad_pkg::STAT_REF_POS] = !st_r.refEnN;
         end else begin
            st_nxt.slverr = 1'b1; // unmapped
         end
      end
      // writes land only at the completing edge
      if (psel && penable && st_r.ready && pwrite && !st_r.slverr) begin
         if (paddr == ADDR_W'(dbad_pkg::WIN_CFG_ADDR)) begin
            st_nxt.lower = pwdata[dbad_pkg::WIN_LOWER_POS +: 8]; // R9
            st_nxt.upper = pwdata[dbad_pkg::WIN_UPPER_POS +: 8]; // R9
            st_nxt.seg = pwdata[dbad_pkg::WIN_SEG_POS +: 2]; // R10
            st_nxt.half = pwdata[dbad_pkg::WIN_HALF_POS]; // R12
         end else if (paddr == ADDR_W'(dbad_pkg::PORT_CFG_ADDR)) begin
            st_nxt.portLow = pwdata[dbad_pkg::PORT_LOW_POS +: 4]; // R5
            st_nxt.port6Hi = pwdata[dbad_pkg::PORT_B6HI_POS]; // R7
            st_nxt.port6Lo = pwdata[dbad_pkg::PORT_B6LO_POS]; // R7
            st_nxt.portHigh = pwdata[dbad_pkg::PORT_HIGH_POS +: 8]; // R8
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.addrS1 <= '0;
         st_r.byteHiS1 <= 1'b1;
         st_r.byteHiS2 <= 1'b1;
         st_r.protS1 <= 1'b1;
         st_r.protS2 <= 1'b1;
         st_r.refSt <= dbad_pkg::REF_IDLE;
         st_r.byteHiOutN <= 1'b1;
         st_r.bselN <= 1'b1;
         st_r.rowSel <= 4'h1;
         st_r.refEnN <= 1'b1;
         st_r.lower <= dbad_pkg::LOWER_RST;
         st_r.upper <= dbad_pkg::UPPER_RST;
         st_r.seg <= dbad_pkg::SEG_RST;
         st_r.half <= dbad_pkg::HALF_RST;
         st_r.portLow <= dbad_pkg::PORT_LOW_RST;
         st_r.portHigh <= dbad_pkg::PORT_HIGH_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output straight from the state flops
   assign memoryAddressOut = st_r.memAddr;
   assign addressBit0True = st_r.adr0;
   assign byteHighEnableOutN = st_r.byteHiOutN;
   assign boardSelectN = st_r.bselN;
   assign parityPortSelect = st_r.portSel;
   assign chipRowSelect = st_r.rowSel;
   assign rowAddrBit17 = st_r.rowBit17;
   assign halfFullOut = st_r.halfOut;
   assign refreshAddressEnableN = st_r.refEnN;
   assign normalAddressEnableN = st_r.normEnN;
   assign protectActive = st_r.protect;
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.slverr;

   ////////////////////////////////////////////////////////////////
   localparam int REF_WAIT_MAX = 3;

   a_row_group: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (!normalAddressEnableN && $past(rowColSel)) |-> memoryAddressOut == $past(rowGrp))
      else $error("row group not on memory address");
   a_col_group: assert property (@(posedge clk) disable iff (!rst_n) // R4
      (!normalAddressEnableN && !$past(rowColSel)) |-> memoryAddressOut == $past(colGrp))
      else $error("column group not on memory address");
   a_refresh_addr: assert property (@(posedge clk) disable iff (!rst_n) // R13
      !refreshAddressEnableN |-> memoryAddressOut == ~$past(rc.rowCount))
      else $error("refresh row not driven inverted");
   a_refresh_delay: assert property (@(posedge clk) disable iff (!rst_n) // R16
      (refreshPulse && st_r.refSt == dbad_pkg::REF_IDLE) |-> ##[1:REF_WAIT_MAX] !refreshAddressEnableN)
      else $error("refresh enable late after pulse");
   a_enable_pair: assert property (@(posedge clk) disable iff (!rst_n) // R13
      refreshAddressEnableN != normalAddressEnableN)
      else $error("address enables not complementary");
   a_port_fixed: assert property (@(posedge clk) disable iff (!rst_n) // R6
      parityPortSelect |-> !$past(addrTrue[4]) && !$past(addrTrue[5]) && !$past(addrTrue[7]))
      else $error("port select with bit 4, 5 or 7 high");
   a_window_bounds: assert property (@(posedge clk) disable iff (!rst_n) // R9
      !boardSelectN |-> ($past(winVal) >= $past(st_r.lower)) && ($past(winVal) <= $past(st_r.upper)))
      else $error("board select outside window");
   a_protect_gate: assert property (@(posedge clk) disable iff (!rst_n) // R22
      protectActive |=> boardSelectN)
      else $error("board selected while protected");
   a_row_onehot: assert property (@(posedge clk) disable iff (!rst_n) // R12
      $onehot(chipRowSelect) && (rowAddrBit17 == $past(addrTrue[17])))
      else $error("chip row select not one-hot or bit 17 stale");
   a_apb_ready: assert property (@(posedge clk) disable iff (!rst_n)
      (psel && !penable && !pready) |=> pready ##1 !pready)
      else $error("apb ready not a single cycle after setup");

   // select details, held against the configuration in force at the deciding edge
   a_port_low_bits: assert property (@(posedge clk) disable iff (!rst_n) // R5
      parityPortSelect |-> (($past(addrTrue[3:0]) ^ $past(st_r.portLow)) == 4'hF))
      else $error("port select with a low address bit at the wrong level");
   a_port_bit6: assert property (@(posedge clk) disable iff (!rst_n) // R7
      parityPortSelect |-> !($past(st_r.port6Hi) && !$past(addrTrue[6]))
         && !($past(st_r.port6Lo) && $past(addrTrue[6])))
      else $error("port select with bit 6 at the wrong level");
   a_port_high_byte: assert property (@(posedge clk) disable iff (!rst_n) // R8
      parityPortSelect |-> (($past(addrTrue[15:8]) & $past(st_r.portHigh)) == 8'h00))
      else $error("port select with a fitted high bit set");
   a_segment_match: assert property (@(posedge clk) disable iff (!rst_n) // R10
      !boardSelectN |-> $past(addrTrue[23:22]) == $past(st_r.seg))
      else $error("board select in the wrong segment");
   a_bit0_true: assert property (@(posedge clk) disable iff (!rst_n) // R1
      addressBit0True == $past(addrTrue[0]))
      else $error("address bit 0 not passed through true");
   a_byte_high_pass: assert property (@(posedge clk) disable iff (!rst_n) // R19
      byteHighEnableOutN == $past(st_r.byteHiS2))
      else $error("byte-high enable not passed through");
   a_row_index: assert property (@(posedge clk) disable iff (!rst_n) // R12
      chipRowSelect == (4'h1 << {$past(st_r.half), $past(addrTrue[17])}))
      else $error("chip row does not follow half setting and bit 17");
   a_protect_load: assert property (@(posedge clk) disable iff (!rst_n) // R17
      refreshEnd |=> protectActive == !$past(st_r.protS2))
      else $error("protection not loaded at refresh end");
   a_protect_hold: assert property (@(posedge clk) disable iff (!rst_n) // R17
      !refreshEnd |=> $stable(protectActive))
      else $error("protection changed outside a refresh end");
endmodule : dbad_top

// File: hw/dbad_pkg.sv
package dbad_pkg;
   // apb register byte offsets
   localparam logic [11:0] WIN_CFG_ADDR = 12'h000;
   localparam logic [11:0] PORT_CFG_ADDR = 12'h004;
   localparam logic [11:0] STATUS_ADDR = 12'h008;
   // window configuration fields
   localparam int WIN_LOWER_POS = 0;
   localparam int WIN_UPPER_POS = 8;
   localparam int WIN_SEG_POS = 16;
   localparam int WIN_HALF_POS = 18;
   // parity port configuration fields
   localparam int PORT_LOW_POS = 0;
   localparam int PORT_B6HI_POS = 4;
   localparam int PORT_B6LO_POS = 5;
   localparam int PORT_HIGH_POS = 6;
   // status fields
   localparam int STAT_ROW_POS = 0;
   localparam int STAT_BSEL_POS = 8;
   localparam int STAT_PSEL_POS = 9;
   localparam int STAT_PROT_POS = 10;
   localparam int STAT_REF_POS = 11;
   // reset values
   localparam logic [7:0] LOWER_RST = 8'h00;
   localparam logic [7:0] UPPER_RST = 8'hFF;
   localparam logic [1:0] SEG_RST = 2'h0;
   localparam logic HALF_RST = 1'b0;
   localparam logic [3:0] PORT_LOW_RST = 4'h0;
   localparam logic [7:0] PORT_HIGH_RST = 8'h00;
   // refresh counter shape
   localparam int REF_STAGES = 2;
   localparam int REF_STAGE_W = 4;
   // timing
   localparam int CLK_MHZ = 40;
   localparam int REF_DELAY_NS = 20;
   localparam int REF_DELAY_CYC_I = (REF_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] REF_DELAY_CYC = (REF_DELAY_CYC_I < 1) ? 4'h1 : 4'(REF_DELAY_CYC_I);
   // refresh sequencer states
   typedef enum logic [2:0] {
      REF_IDLE = 3'b001,
      REF_WAIT = 3'b010,
      REF_RUN = 3'b100
   } dbad_ref_st_t;
endpackage : dbad_pkg

// File: hw/dbad_ref_if.sv
`timescale 1ns/1ps
interface dbad_ref_if;
   logic countPulse;
   logic [7:0] rowCount;
   modport ctrl (output countPulse, input rowCount);
   modport cnt (input countPulse, output rowCount);
endinterface : dbad_ref_if

// File: hw/dbad_refresh_counter.sv
`timescale 1ns/1ps
module dbad_refresh_counter #(
   parameter int STAGES = dbad_pkg::REF_STAGES,
   parameter int STAGE_W = dbad_pkg::REF_STAGE_W
) (
   input wire logic clk,
   input wire logic rst_n,
   dbad_ref_if.cnt rc
);
   typedef struct packed {
      logic [STAGES-1:0][STAGE_W-1:0] stage;
   } dbad_cnt_state_t;

   dbad_cnt_state_t st_r;
   dbad_cnt_state_t st_nxt;
   logic [STAGES:0] carry;

   ////////////////////////////////////////////////////////////////
   // ripple carry between cascaded stages
   assign carry[0] = rc.countPulse; // R14
   genvar g;
   generate
      for (g = 0; g < STAGES; g++) begin : gStage
         assign carry[g+1] = carry[g] & (&st_r.stage[g]); // R15
      end
   endgenerate

   // each stage adds its incoming carry
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < STAGES; i++) begin
         st_nxt.stage[i] = STAGE_W'(st_r.stage[i] + {{(STAGE_W-1){1'b0}}, carry[i]}); // R14
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rc.rowCount = st_r.stage;

   ////////////////////////////////////////////////////////////////
   a_counter_step: assert property (@(posedge clk) disable iff (!rst_n) // R14
      rc.countPulse |=> rc.rowCount == 8'($past(rc.rowCount) + 8'h01))
      else $error("refresh row counter did not advance by one");
   a_counter_hold: assert property (@(posedge clk) disable iff (!rst_n) // R15
      !rc.countPulse |=> rc.rowCount == $past(rc.rowCount))
      else $error("refresh row counter moved without a count pulse");
endmodule : dbad_refresh_counter

// File: tb/dbad_bus_master.sv
`timescale 1ns/1ps
module dbad_bus_master (
   input wire logic clk,
   input wire logic [23:0] reqAddr,
   input wire logic reqBheN,
   input wire logic reqProtN,
   output logic [23:0] busAddrN,
   output logic byteHighEnableN,
   output logic protectRequestN
);
   ////////////////////////////////////////////////////////////
   // idle bus: all lines released high, nothing asserted
   initial begin
      busAddrN = 24'hFFFFFF;
      byteHighEnableN = 1'b1;
      protectRequestN = 1'b1;
   end

   // all 24 lines are driven, so every segment can be reached
   always @(posedge clk) begin
      busAddrN <= ~reqAddr;
      byteHighEnableN <= reqBheN;
      protectRequestN <= reqProtN;
   end
endmodule : dbad_bus_master

// File: tb/dbad_tb_top.sv
`timescale 1ns/1ps
module dbad_tb_top;
   typedef struct packed {logic [23:0] addr; logic byte_high_enable_n; logic expBselN; logic expPsel;} dbad_row_t;
   logic clk = 1'b0, rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdat;
   logic pready, pslverr, err;
   logic [23:0] reqAddr = 24'h000000, busAddrN;
   logic reqBheN = 1'b1, reqProtN = 1'b1, rowColSel = 1'b1, refreshPulse = 1'b0, refreshEnd = 1'b0;
   logic byteHighEnableN, protectRequestN, addressBit0True, byteHighEnableOutN, boardSelectN;
   logic parityPortSelect, rowAddrBit17, halfFullOut, refreshAddressEnableN, normalAddressEnableN, protectActive;
   logic [7:0] memoryAddressOut, refCount;
   logic [3:0] chipRowSelect;
   int badCount = 0, checksDone = 0, cycles = 0;
   // window 10..20, segment 2; port jumpers on bits 0,2,8,9 and bit6-high
   dbad_row_t rows [12] = '{'{24'h84FC4A, 1'b0, 1'b0, 1'b1}, '{24'h84FC4B, 1'b1, 1'b0, 1'b0},
      '{24'h84FC0A, 1'b0, 1'b0, 1'b0}, '{24'h84FD4A, 1'b1, 1'b0, 1'b0}, '{24'h84FCCA, 1'b0, 1'b0, 1'b0},
      '{24'h84FC5B, 1'b0, 1'b0, 1'b0}, '{24'h840C4A, 1'b1, 1'b0, 1'b1}, '{24'h880000, 1'b0, 1'b0, 1'b0},
      '{24'h884000, 1'b0, 1'b1, 1'b0}, '{24'h83C000, 1'b1, 1'b1, 1'b0}, '{24'h480000, 1'b0, 1'b1, 1'b0},
      '{24'h860001, 1'b1, 1'b0, 1'b0}};

   always #12.5 clk = ~clk;

   dbad_bus_master dbad_bus_master_inst (.clk, .reqAddr, .reqBheN, .reqProtN, .busAddrN, .byteHighEnableN,
      .protectRequestN);
   dbad_top dbad_top_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .busAddrN, .byteHighEnableN, .protectRequestN, .rowColSel, .refreshPulse, .refreshEnd, .memoryAddressOut,
      .addressBit0True, .byteHighEnableOutN, .boardSelectN, .parityPortSelect, .chipRowSelect, .rowAddrBit17,
      .halfFullOut, .refreshAddressEnableN, .normalAddressEnableN, .protectActive);

   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] rowGrp(input logic [23:0] a);
      return {a[15], a[7:1]};
   endfunction : rowGrp

   function automatic logic [7:0] colGrp(input logic [23:0] a);
      return {a[16], a[8], a[14:9]};
   endfunction : colGrp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task finish_test;
      if (badCount == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no own limit: a missing pready is left to the hang guard
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // partner flop plus two sync stages plus output flop
   task automatic present(input logic [23:0] a, input logic byte_high_enable_n);
      @(posedge clk);
      reqAddr <= a;
      reqBheN <= byte_high_enable_n;
      rowColSel <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
   endtask : present

   task automatic refreshOnce;
      @(posedge clk) refreshPulse <= 1'b1;
      @(posedge clk) refreshPulse <= 1'b0;
      refCount++;
      @(posedge clk) #1;
      chk(refreshAddressEnableN, 1'b0);
      chk(normalAddressEnableN, 1'b1);
      chk(memoryAddressOut, 8'(~refCount));
      @(posedge clk) refreshEnd <= 1'b1;
      @(posedge clk) refreshEnd <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(normalAddressEnableN, 1'b0);
   endtask : refreshOnce

   ////////////////////////////////////////////////////////////
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         finish_test;
      end
   end

   initial begin
      refCount = 8'h00;
      repeat (5) @(posedge clk);
      #1 chk(boardSelectN, 1'b1);
      chk(chipRowSelect, 4'h1);
      chk(refreshAddressEnableN, 1'b1);
      chk(byteHighEnableOutN, 1'b1);
      @(posedge clk) rst_n <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h0000FF00);
      apb(1'b0, 12'h00C, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 12'h000, 32'h00062010);
      apb(1'b1, 12'h004, 32'h000000D5);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h000000D5);
      chk(err, 1'b0);
      // table of decode cases, both address groups each
      foreach (rows[i]) begin
         present(rows[i].addr, rows[i].byte_high_enable_n);
         chk(boardSelectN, rows[i].expBselN);
         chk(parityPortSelect, rows[i].expPsel);
         chk(addressBit0True, rows[i].addr[0]);
         chk(byteHighEnableOutN, rows[i].byte_high_enable_n);
         chk(chipRowSelect, 32'h1 << {1'b1, rows[i].addr[17]});
         chk(rowAddrBit17, rows[i].addr[17]);
         chk(halfFullOut, 1'b1);
         chk(memoryAddressOut, rowGrp(rows[i].addr));
         @(posedge clk) rowColSel <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk(memoryAddressOut, colGrp(rows[i].addr));
      end
      // second bit-6 jumper flips the required level
      apb(1'b1, 12'h004, 32'h000000E5);
      present(24'h84FC0A, 1'b1);
      chk(parityPortSelect, 1'b1);
      present(24'h84FC4A, 1'b1);
      chk(parityPortSelect, 1'b0);
      apb(1'b1, 12'h000, 32'h00022010);
      present(24'h860001, 1'b1);
      chk(chipRowSelect, 4'h2);
      chk(halfFullOut, 1'b0);
      // seventeen refreshes carry across the stage boundary
      repeat (17) refreshOnce;
      apb(1'b0, 12'h008, 32'h0);
      chk(rdat[7:0], refCount);
      chk(rdat[11:8], 4'h1);
      // protection blocks selection but refresh goes on
      present(24'h840C4A, 1'b1);
      chk(boardSelectN, 1'b0);
      @(posedge clk) reqProtN <= 1'b0;
      repeat (5) @(posedge clk);
      refreshOnce;
      repeat (3) @(posedge clk);
      #1 chk(protectActive, 1'b1);
      chk(boardSelectN, 1'b1);
      refreshOnce;
      @(posedge clk) reqProtN <= 1'b1;
      repeat (5) @(posedge clk);
      refreshOnce;
      repeat (3) @(posedge clk);
      #1 chk(protectActive, 1'b0);
      chk(boardSelectN, 1'b0);
      // reset in mid-run: configuration and refresh row start over
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(refreshAddressEnableN, 1'b1);
      chk(normalAddressEnableN, 1'b0);
      @(posedge clk) rst_n <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h00000000);
      present(24'h040C4F, 1'b1);
      chk(parityPortSelect, 1'b1);
      chk(boardSelectN, 1'b0);
      refCount = 8'h00;
      refreshOnce;
      finish_test;
   end
endmodule : dbad_tb_top
